/* sbl_pkg.sv */
// Shared types and constants for the serial boot loader command interpreter.
// Assumes a single 20 MHz clock and an external flash controller with a done/fail handshake.
package sbl_pkg;

  // Protocol bytes
  localparam logic [7:0] SBL_ACK = 8'hcc;
  localparam logic [7:0] SBL_NAK = 8'h33;
  localparam logic [7:0] SBL_SYNC_OK = 8'hcc;

  // Command codes
  localparam logic [7:0] CMD_PING = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
  localparam logic [7:0] CMD_RUN = 8'h22;
  localparam logic [7:0] cmd_query_result = 8'h23;
  localparam logic [7:0] CMD_SEND_DATA = 8'h24;
  localparam logic [7:0] CMD_RESET = 8'h25;

  // Status codes (values arbitrary)
  localparam logic [7:0] STAT_OK = 8'h40;
  localparam logic [7:0] STAT_UNKNOWN = 8'h41;
  localparam logic [7:0] STAT_INVALID = 8'h42;
  localparam logic [7:0] STAT_FLASH_FAIL = 8'h43;

  // Packet framing
  localparam logic [7:0] PKT_MIN_LEN = 8'h03;
  localparam logic [7:0] PAY_MAX = 8'h10;
  localparam logic [7:0] PKT_MAX_LEN = 8'h12;
  localparam logic [7:0] LEN_DOWNLOAD = 8'h0b;
  localparam logic [7:0] LEN_RUN = 8'h07;
  localparam logic [7:0] RESP_LEN = 8'h03;

  // Autobaud: edges 1..9 of the sync pattern span 16 bit times
  localparam logic [3:0] AB_EDGE_MEAS = 4'h8;
  localparam logic [3:0] AB_EDGE_LAST = 4'h9;
  localparam int AB_SHIFT = 4;
  localparam logic [3:0] UART_STOP_BIT = 4'h9;

  // Synchroniser lane positions
  localparam int PIN_RXD = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_FSS = 3;

  typedef enum logic [1:0] {P_NONE, P_UART, P_SSI} sbl_port_e;

  typedef enum logic [3:0] {
    S_LEN, S_SUM, S_DATA, S_CHK, S_ACK, S_EXEC, S_PROG, S_RLEN, S_RSUM, S_RDAT, S_RWAIT
  } sbl_phase_e;

  typedef struct packed {
    logic erase;
    logic prog;
    logic [31:0] addr;
    logic [31:0] size;
    logic [7:0] data;
  } sbl_flash_req_s;

  typedef struct packed {
    logic [3:0][2:0] sy;
    logic [3:0] filt;
    sbl_port_e port;
    logic meas_on;
    logic [3:0] edge_cnt;
    logic [19:0] meas;
    logic [15:0] bit_len;
    logic rx_busy;
    logic rx_skip;
    logic [15:0] rx_tmr;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic tx_busy;
    logic [15:0] tx_tmr;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic txd;
    logic [2:0] s_bit;
    logic s_act;
    logic [7:0] s_rx;
    logic [7:0] s_tx;
    logic miso;
    logic tx_req;
    logic [7:0] tx_byte;
    sbl_phase_e st;
    sbl_phase_e after;
    logic [7:0] packet_length_byte;
    logic [7:0] packet_sum_byte;
    logic [7:0] calc;
    logic [7:0] idx;
    logic [15:0][7:0] pay;
    logic [7:0] status;
    logic [31:0] paddr;
    logic [31:0] remain;
    logic pfail;
    sbl_flash_req_s fl;
    logic run;
    logic [31:0] run_addr;
    logic srst;
  } sbl_state_s;

  localparam sbl_state_s SBL_RST = '{sy: 12'hfff, filt: 4'hf, port: P_NONE, txd: 1'b1, miso: 1'b1,
    st: S_LEN, after: S_LEN, status: STAT_OK, default: '0};

endpackage

/* sbl_loader.sv */
// Serial boot loader command interpreter: UART with autobaud or SSI slave, packet engine, flash requests.
// Assumes the flash controller answers each erase/program request with FLASH_DONE_I (and FLASH_FAIL_I).
//
// Notes on behaviour
// - UART characters are 8 data bits, no parity, one stop bit.
// - Host sends two 0x55 bytes; device measures bit time, answers 0xCC.
// - First port used is locked; the other is ignored until reset.
// - SSI is Motorola format, phase one, polarity one, device is slave.
// - Packets open with total length byte; payload is length minus two.
// - Second byte is sum of payload bytes only.
// - Device answers each received packet with 0xCC good or 0x33 bad.
// - Device may pad with zeros, then sends its packet without a break.
// - Device skips zero padding; first non-zero byte is the host answer.
// - First payload byte is the command; the rest are parameters.
// - Ping 0x20 in three-byte packet only sets status to success.
// - Query 0x23 returns one-byte packet with last status; host answers it.
// - Download 0x21, eleven bytes: 32-bit address then size, MSB first.
// - A valid download erases the target area before the acknowledge goes out.
// - After download, status tells whether address and size are valid.
// - Data 0x24 programs from where the last ended until count is done.
// - Rejected data packet leaves the programming address unchanged.
// - Run 0x22 carries a 32-bit address; acknowledge first, then execute.
// - Reset 0x25 is acknowledged, then a full software reset follows.
`timescale 1ns/1ns

module sbl_loader #(
  parameter logic [31:0] FLASH_BYTES = 32'h0000_8000
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Asynchronous serial port
  input wire logic UART_RXD_I,
  output logic UART_TXD_O,
  // Synchronous serial port, slave
  input wire logic SSI_CLK_I,
  input wire logic SSI_RX_I,
  input wire logic SSI_FRAME_N_I,
  output logic SSI_TX_O,
  output logic SSI_TX_OE_N_O,
  // Flash controller
  output sbl_pkg::sbl_flash_req_s FLASH_REQ_O,
  input wire logic FLASH_DONE_I,
  input wire logic FLASH_FAIL_I,
  // Hand-off
  output logic RUN_O,
  output logic [31:0] RUN_ADDR_O,
  output logic SOFT_RESET_O,
  output sbl_pkg::sbl_port_e LINK_O
);
  import sbl_pkg::*;

  sbl_state_s q;
  sbl_state_s n;

  function automatic logic [31:0] be32(input logic [15:0][7:0] p, input int at);
    be32 = {p[at], p[at + 1], p[at + 2], p[at + 3]};
  endfunction

  always_comb
  begin
    logic [3:0] pins;
    logic rx_fall;
    logic sck_fall;
    logic sck_rise;
    logic got;
    logic [7:0] b;
    logic s_got;
    logic [7:0] sb;
    logic [7:0] cur;
    logic tx_idle;
    logic good;
    logic [31:0] dl_addr;
    logic [31:0] dl_size;
    pins = {SSI_FRAME_N_I, SSI_RX_I, SSI_CLK_I, UART_RXD_I};
    got = 1'b0;
    b = 8'h00;
    s_got = 1'b0;
    sb = 8'h00;
    cur = 8'h00;
    good = 1'b0;
    dl_addr = be32(q.pay, 1);
    dl_size = be32(q.pay, 5);
    n = q;
    n.run = 1'b0;
    n.srst = 1'b0;

    // Three-stage pin capture; a level counts once stages two and three agree
    for (int i = 0; i < 4; i++)
    begin
      n.sy[i] = {q.sy[i][1:0], pins[i]};
      if (q.sy[i][1] == q.sy[i][2])
        n.filt[i] = q.sy[i][2];
    end
    rx_fall = q.filt[PIN_RXD] & ~n.filt[PIN_RXD];
    sck_fall = q.filt[PIN_SCK] & ~n.filt[PIN_SCK];
    sck_rise = ~q.filt[PIN_SCK] & n.filt[PIN_SCK];
    tx_idle = !q.tx_req && !q.tx_busy && !q.s_act;

    // Autobaud on the sync pair while no port is locked
    if (q.port == P_NONE)
    begin
      if (q.meas_on)
        n.meas = q.meas + 20'h1;
      if (q.meas_on && (&q.meas))
      begin
        n.meas_on = 1'b0;
        n.edge_cnt = 4'h0;
      end
      else if (rx_fall)
      begin
        if (!q.meas_on)
        begin
          n.meas_on = 1'b1;
          // Fall cycle counts too, so sixteen bit times read as exactly sixteen
          n.meas = 20'h1;
          n.edge_cnt = 4'h0;
        end
        else
        begin
          n.edge_cnt = q.edge_cnt + 4'h1;
          if (q.edge_cnt == AB_EDGE_MEAS - 4'h1)
            n.bit_len = q.meas[AB_SHIFT +: 16];
          if (q.edge_cnt == AB_EDGE_LAST - 4'h1)
          begin
            // Last pattern frame is swallowed so it never reads as a length byte
            n.meas_on = 1'b0;
            n.port = P_UART;
            n.rx_busy = 1'b1;
            n.rx_skip = 1'b1;
            n.rx_bit = 4'h0;
            n.rx_tmr = {1'b0, q.bit_len[15:1]};
            n.tx_req = 1'b1;
            n.tx_byte = SBL_SYNC_OK;
          end
        end
      end
    end

    // UART receiver and transmitter, 8N1
    if (q.port == P_UART)
    begin
      if (!q.rx_busy)
      begin
        if (rx_fall)
        begin
          n.rx_busy = 1'b1;
          n.rx_bit = 4'h0;
          n.rx_tmr = {1'b0, q.bit_len[15:1]};
        end
      end
      else if (q.rx_tmr != 16'h0)
        n.rx_tmr = q.rx_tmr - 16'h1;
      else
      begin
        n.rx_tmr = q.bit_len - 16'h1;
        n.rx_bit = q.rx_bit + 4'h1;
        if (q.rx_bit == 4'h0 && q.filt[PIN_RXD])
          n.rx_busy = 1'b0;
        else if (q.rx_bit == UART_STOP_BIT)
        begin
          n.rx_busy = 1'b0;
          n.rx_skip = 1'b0;
          got = q.filt[PIN_RXD] && !q.rx_skip;
          b = q.rx_sh;
        end
        else if (q.rx_bit != 4'h0)
          n.rx_sh = {q.filt[PIN_RXD], q.rx_sh[7:1]};
      end
      if (!q.tx_busy)
      begin
        if (q.tx_req)
        begin
          n.tx_req = 1'b0;
          n.tx_busy = 1'b1;
          n.tx_sh = {1'b1, q.tx_byte, 1'b0};
          n.tx_bit = 4'h0;
          n.tx_tmr = q.bit_len - 16'h1;
        end
      end
      else if (q.tx_tmr != 16'h0)
        n.tx_tmr = q.tx_tmr - 16'h1;
      else
      begin
        n.tx_tmr = q.bit_len - 16'h1;
        n.tx_sh = {1'b1, q.tx_sh[9:1]};
        n.tx_bit = q.tx_bit + 4'h1;
        if (q.tx_bit == UART_STOP_BIT)
          n.tx_busy = 1'b0;
      end
    end
    n.txd = n.tx_busy ? n.tx_sh[0] : 1'b1;

    // SSI slave, mode 3: drive on falling, sample on rising; SCK at most clk/12 keeps edges visible
    if (q.port != P_UART)
    begin
      if (q.filt[PIN_FSS])
      begin
        n.s_bit = 3'h0;
        n.s_act = 1'b0;
      end
      else
      begin
        if (sck_fall)
        begin
          if (q.s_bit == 3'h0)
          begin
            // Nothing queued means a zero pad byte goes out
            if (q.tx_req && q.port == P_SSI)
            begin
              cur = q.tx_byte;
              n.tx_req = 1'b0;
            end
            n.miso = cur[7];
            n.s_tx = {cur[6:0], 1'b0};
            n.s_act = 1'b1;
          end
          else
          begin
            n.miso = q.s_tx[7];
            n.s_tx = {q.s_tx[6:0], 1'b0};
          end
        end
        if (sck_rise)
        begin
          n.s_rx = {q.s_rx[6:0], q.filt[PIN_MOSI]};
          n.s_bit = q.s_bit + 3'h1;
          if (q.s_bit == 3'h7)
          begin
            n.s_act = 1'b0;
            s_got = 1'b1;
            sb = {q.s_rx[6:0], q.filt[PIN_MOSI]};
          end
        end
      end
      if (s_got && q.port == P_SSI)
      begin
        got = 1'b1;
        b = sb;
      end
      else if (s_got && sb != 8'h00 && q.port == P_NONE)
      begin
        n.port = P_SSI;
        n.meas_on = 1'b0;
        got = 1'b1;
        b = sb;
      end
    end

    // Packet engine
    unique case (q.st)
      S_LEN:
        if (got && b != 8'h00)
        begin
          n.packet_length_byte = b;
          n.calc = 8'h00;
          n.idx = 8'h00;
          n.st = S_SUM;
        end
      S_SUM:
        if (got)
        begin
          n.packet_sum_byte = b;
          n.st = (q.packet_length_byte < PKT_MIN_LEN) ? S_CHK : S_DATA;
        end
      S_DATA:
        if (got)
        begin
          n.calc = q.calc + b;
          if (q.idx < PAY_MAX)
            n.pay[q.idx[3:0]] = b;
          n.idx = q.idx + 8'h1;
          if (q.idx == q.packet_length_byte - 8'h03)
            n.st = S_CHK;
        end
      S_CHK:
      begin
        good = q.calc == q.packet_sum_byte && q.packet_length_byte >= PKT_MIN_LEN &&
          q.packet_length_byte <= PKT_MAX_LEN;
        n.st = S_ACK;
        n.after = S_EXEC;
        n.tx_req = 1'b1;
        n.tx_byte = SBL_ACK;
        if (!good)
        begin
          n.tx_byte = SBL_NAK;
          n.after = S_LEN;
        end
        else if (q.pay[0] == CMD_DOWNLOAD)
        begin
          n.tx_req = 1'b0;
          n.st = S_EXEC;
        end
      end
      S_ACK:
        if (tx_idle)
          n.st = q.after;
      S_EXEC:
      begin
        n.st = S_LEN;
        unique case (q.pay[0])
          CMD_PING:
            n.status = (q.packet_length_byte == PKT_MIN_LEN) ? STAT_OK : STAT_INVALID;
          cmd_query_result:
            n.st = S_RLEN;
          CMD_DOWNLOAD:
          begin
            n.st = S_ACK;
            n.after = S_LEN;
            if (!q.fl.erase)
            begin
              if (q.packet_length_byte != LEN_DOWNLOAD || dl_size == 32'h0 || dl_addr >= FLASH_BYTES ||
                dl_size > FLASH_BYTES - dl_addr)
              begin
                n.status = STAT_INVALID;
                n.remain = 32'h0;
                n.tx_req = 1'b1;
                n.tx_byte = SBL_ACK;
              end
              else
              begin
                n.paddr = dl_addr;
                n.remain = dl_size;
                n.fl.erase = 1'b1;
                n.fl.addr = dl_addr;
                n.fl.size = dl_size;
                n.st = S_EXEC;
              end
            end
            else if (FLASH_DONE_I)
            begin
              n.fl.erase = 1'b0;
              n.status = FLASH_FAIL_I ? STAT_FLASH_FAIL : STAT_OK;
              n.tx_req = 1'b1;
              n.tx_byte = SBL_ACK;
            end
            else
              n.st = S_EXEC;
          end
          CMD_SEND_DATA:
            if (q.remain == 32'h0)
              n.status = STAT_INVALID;
            else
            begin
              n.pfail = 1'b0;
              n.idx = 8'h01;
              n.st = S_PROG;
            end
          CMD_RUN:
            if (q.packet_length_byte != LEN_RUN)
              n.status = STAT_INVALID;
            else
            begin
              n.run_addr = be32(q.pay, 1);
              n.run = 1'b1;
              n.status = STAT_OK;
            end
          CMD_RESET:
            n.srst = 1'b1;
          default:
            n.status = STAT_UNKNOWN;
        endcase
      end
      S_PROG:
        if (!q.fl.prog)
        begin
          if (q.idx == q.packet_length_byte - 8'h02 || q.remain == 32'h0)
          begin
            n.status = q.pfail ? STAT_FLASH_FAIL : STAT_OK;
            n.st = S_LEN;
          end
          else
          begin
            n.fl.prog = 1'b1;
            n.fl.addr = q.paddr;
            n.fl.data = q.pay[q.idx[3:0]];
          end
        end
        else if (FLASH_DONE_I)
        begin
          // Address advances only for data that was acknowledged and executed
          n.fl.prog = 1'b0;
          n.paddr = q.paddr + 32'h1;
          n.remain = q.remain - 32'h1;
          n.idx = q.idx + 8'h1;
          if (FLASH_FAIL_I)
            n.pfail = 1'b1;
        end
      S_RLEN:
        if (!q.tx_req)
        begin
          n.tx_req = 1'b1;
          n.tx_byte = RESP_LEN;
          n.st = S_RSUM;
        end
      S_RSUM:
        if (!q.tx_req)
        begin
          n.tx_req = 1'b1;
          n.tx_byte = q.status;
          n.st = S_RDAT;
        end
      S_RDAT:
        if (!q.tx_req)
        begin
          n.tx_req = 1'b1;
          n.tx_byte = q.status;
          n.st = S_RWAIT;
        end
      S_RWAIT:
        if (got && b != 8'h00)
          n.st = S_LEN;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)
      q <= SBL_RST;
    else
      q <= n;
  end

  assign UART_TXD_O = q.txd;
  assign SSI_TX_O = q.miso;
  assign SSI_TX_OE_N_O = q.filt[PIN_FSS] || q.port == P_UART;
  assign FLASH_REQ_O = q.fl;
  assign RUN_O = q.run;
  assign RUN_ADDR_O = q.run_addr;
  assign SOFT_RESET_O = q.srst;
  assign LINK_O = q.port;

endmodule // sbl_loader

/* sbl_host_model.sv */
// Host side of the asynchronous serial link: 8N1 sender, background receiver, sync retry.
// Assumes the loader clock drives clk; bit time is counted in those clocks.
`timescale 1ns/1ns

module sbl_host_model #(
  parameter int BIT = 32 // Clock over 32, also below clock over 16
) (
  // Loader clock
  input wire logic clk,
  // Serial lines
  output logic rxd,
  input wire logic txd
);
  logic [7:0] rxq[$];
  logic [7:0] rb;

  initial rxd = 1'b1;

  // LSB first, no parity, one stop bit
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      rxd = f[i];
      repeat (BIT - 1) @(negedge clk);
    end
  endtask

  // Zero padding is skipped; first non-zero byte is the answer
  task automatic get(output logic [7:0] b, input int lim);
    repeat (lim)
    begin
      @(posedge clk);
      if (rxq.size() > 0)
      begin
        b = rxq.pop_front();
        if (b != 8'h00)
          return;
      end
    end
    b = 8'hxx;
  endtask

  // Pattern resent when the answer misses twice the pattern time
  task automatic sync(output logic [7:0] b);
    repeat (3)
    begin
      put(8'h55);
      put(8'h55);
      get(b, 40 * BIT);
      if (b === 8'hcc)
        return;
    end
  endtask

  // Runs free so an answer that starts inside our stop bit is not lost
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    if (!txd)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge clk);
        rb[i] = txd;
      end
      repeat (BIT) @(posedge clk);
      if (txd)
        rxq.push_back(rb);
    end
  end
endmodule // sbl_host_model

/* sbl_loader_assertions.sv */
// Port checker for the boot loader, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ns

module sbl_loader_checker #(
  parameter logic [31:0] FLASH_BYTES = 32'h0000_8000
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Watched ports
  input wire logic UART_TXD_O,
  input wire logic SSI_TX_OE_N_O,
  input wire sbl_pkg::sbl_flash_req_s FLASH_REQ_O,
  input wire logic FLASH_DONE_I,
  input wire logic RUN_O,
  input wire logic [31:0] RUN_ADDR_O,
  input wire logic SOFT_RESET_O,
  input wire sbl_pkg::sbl_port_e LINK_O
);
  import sbl_pkg::*;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);

  chk_reset_idle: assert property ($rose(NRST_I) |-> UART_TXD_O && LINK_O == P_NONE)
    else $error("outputs not idle after reset");
  chk_link_held: assert property (LINK_O != P_NONE |=> $stable(LINK_O))
    else $error("locked port changed");
  chk_ssi_muted: assert property (LINK_O == P_UART |-> SSI_TX_OE_N_O)
    else $error("sync port driven while async port locked");
  chk_erase_quiet: assert property (FLASH_REQ_O.erase |-> UART_TXD_O && !FLASH_REQ_O.prog)
    else $error("answer or program during erase");
  chk_erase_hold: assert property (FLASH_REQ_O.erase && !FLASH_DONE_I |=>
    FLASH_REQ_O.erase && $stable(FLASH_REQ_O.addr))
    else $error("erase request not held");
  chk_ack_after: assert property (FLASH_REQ_O.erase && FLASH_DONE_I |-> ##[1:40] !UART_TXD_O)
    else $error("no answer after erase done");
  chk_erase_valid: assert property (FLASH_REQ_O.erase |-> FLASH_REQ_O.size != 0 &&
    {1'b0, FLASH_REQ_O.addr} + FLASH_REQ_O.size <= {1'b0, FLASH_BYTES})
    else $error("erase of invalid area");
  chk_req_drop: assert property ((FLASH_REQ_O.prog || FLASH_REQ_O.erase) && FLASH_DONE_I |=> !FLASH_REQ_O.prog)
    else $error("program request kept after done");
  chk_run_once: assert property (RUN_O |=> !RUN_O [*8] ##0 $stable(RUN_ADDR_O))
    else $error("run pulse or address unstable");
  chk_run_after: assert property (RUN_O |-> UART_TXD_O && $past(UART_TXD_O))
    else $error("run before answer finished");
  chk_reset_pulse: assert property (SOFT_RESET_O |-> UART_TXD_O ##1 !SOFT_RESET_O)
    else $error("soft reset pulse wrong");

  cov_erase: cover property (FLASH_REQ_O.erase && FLASH_DONE_I);
  cov_run: cover property (RUN_O);
  cov_reset: cover property (SOFT_RESET_O);
  cov_ssi: cover property (LINK_O == P_SSI);
endmodule // sbl_loader_checker

bind sbl_loader sbl_loader_checker #(.FLASH_BYTES(FLASH_BYTES)) chk_u (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .UART_TXD_O(UART_TXD_O), .SSI_TX_OE_N_O(SSI_TX_OE_N_O), .FLASH_REQ_O(FLASH_REQ_O),
  .FLASH_DONE_I(FLASH_DONE_I), .RUN_O(RUN_O), .RUN_ADDR_O(RUN_ADDR_O), .SOFT_RESET_O(SOFT_RESET_O),
  .LINK_O(LINK_O));

/* serial_boot_loader_protocol_test.sv */
// Self-checking bench for the boot loader over the asynchronous port, then the synchronous one.
// Assumes the host model and a small flash responder stand around the block.
`timescale 1ns/1ns

module serial_boot_loader_protocol_test;
  import sbl_pkg::*;
  logic clk, rst_n, rxd, txd, sck, mosi, fss_n, miso, miso_oe_n, run, srst;
  logic fdone = 1'b0;
  logic ffail = 1'b0;
  logic [31:0] run_addr, ea, es, ra;
  sbl_flash_req_s fr;
  sbl_port_e link;
  int seed = 42;
  int bad_count, num_checks, ne, wt, n;
  bit use_ssi;
  logic [7:0] st, b;
  logic [7:0] pk[$], pa_d[$], ed[$];
  logic [31:0] pa[$];

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  sbl_host_model #(.BIT(32)) host_u (.clk(clk), .rxd(rxd), .txd(txd));

  sbl_loader dut_u (.CLK_I(clk), .NRST_I(rst_n), .UART_RXD_I(rxd), .UART_TXD_O(txd),
    .SSI_CLK_I(sck), .SSI_RX_I(mosi), .SSI_FRAME_N_I(fss_n), .SSI_TX_O(miso),
    .SSI_TX_OE_N_O(miso_oe_n), .FLASH_REQ_O(fr), .FLASH_DONE_I(fdone), .FLASH_FAIL_I(ffail),
    .RUN_O(run), .RUN_ADDR_O(run_addr), .SOFT_RESET_O(srst), .LINK_O(link));

  // Flash stand-in: answers every request after a short wait and logs it
  always @(negedge clk)
  begin
    fdone <= 1'b0;
    if ((fr.erase || fr.prog) && !fdone)
    begin
      wt <= wt + 1;
      if (wt == 3)
      begin
        fdone <= 1'b1;
        wt <= 0;
        if (fr.erase)
        begin
          ne++;
          ea = fr.addr;
          es = fr.size;
        end
        else
        begin
          pa.push_back(fr.addr);
          pa_d.push_back(fr.data);
        end
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Mode 3 byte, MSB first: drive on fall, sample on rise, SCK at clock over 12
  task automatic sx(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      repeat (6) @(negedge clk);
      sck = 1'b0;
      mosi = t[i];
      repeat (6) @(negedge clk);
      sck = 1'b1;
      r[i] = miso;
    end
  endtask

  // Zero pad bytes clocked until a non-zero byte shows, bounded
  task automatic sget(output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < 8 && r == 8'h00; i++) sx(8'h00, r);
  endtask

  // One byte to the device on whichever port is in use
  task automatic put_b(input logic [7:0] v);
    logic [7:0] r;
    if (use_ssi)
      sx(v, r);
    else
      host_u.put(v);
  endtask

  task automatic get_b(output logic [7:0] v, input int lim);
    if (use_ssi)
      sget(v);
    else
      host_u.get(v, lim);
  endtask

  // Modulo-256 sum of payload; flip spoils the sum on purpose
  task automatic send(input logic [7:0] p[$], input logic [7:0] flip, input logic [7:0] ack);
    int sum;
    logic [7:0] a;
    sum = 0;
    foreach (p[i]) sum += p[i];
    put_b(8'(p.size() + 2));
    put_b(8'(sum) ^ flip);
    foreach (p[i]) put_b(p[i]);
    get_b(a, 4000);
    chk("answer", ack, a);
  endtask

  task automatic query();
    logic [7:0] l, s, d;
    send('{cmd_query_result}, 8'h00, SBL_ACK);
    get_b(l, 800);
    get_b(s, 800);
    get_b(d, 800);
    chk("reply length", RESP_LEN, l);
    chk("reply sum", st, s);
    chk("status", st, d);
    put_b(8'h00);
    put_b(SBL_ACK);
  endtask

  task automatic w32(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) pk.push_back(v[8*i+:8]);
  endtask

  // Random traffic on the sync port, SCK at clock over 12
  task automatic ssi_noise();
    @(negedge clk);
    fss_n = 1'b0;
    repeat (60)
    begin
      repeat (6) @(negedge clk);
      sck = ~sck;
      mosi = 1'($random(seed));
    end
    chk("miso oe", 1, miso_oe_n);
    fss_n = 1'b1;
  endtask

  task automatic reset_sync();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("link idle", P_NONE, link);
    host_u.sync(b);
    chk("sync answer", SBL_SYNC_OK, b);
    chk("link", P_UART, link);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    sck = 1'b1;
    mosi = 1'b0;
    fss_n = 1'b1;
    st = STAT_OK;
    reset_sync();
    fork
      ssi_noise();
      send('{CMD_PING}, 8'h00, SBL_ACK);
    join
    chk("link kept", P_UART, link);
    send('{8'h30}, 8'h00, SBL_ACK);
    st = STAT_UNKNOWN;
    query();
    send('{CMD_PING}, 8'h01, SBL_NAK);
    query();
    send('{CMD_PING}, 8'h00, SBL_ACK);
    st = STAT_OK;
    pk = '{CMD_DOWNLOAD};
    w32(32'h0000_0100);
    w32(32'h0000_0000);
    send(pk, 8'h00, SBL_ACK);
    st = STAT_INVALID;
    query();
    chk("erase count", 0, ne);
    pk = '{CMD_DOWNLOAD};
    w32(32'h0000_0100);
    w32(32'h0000_0008);
    send(pk, 8'h00, SBL_ACK);
    st = STAT_OK;
    chk("erase done", 1, ne);
    chk("erase addr", 32'h0000_0100, ea);
    chk("erase size", 32'h0000_0008, es);
    query();
    for (int k = 0; k < 2; k++)
    begin
      pk = '{CMD_SEND_DATA};
      repeat (4) pk.push_back(8'($random(seed)));
      if (k == 1)
        send(pk, 8'h5a, SBL_NAK);
      send(pk, 8'h00, SBL_ACK);
      for (int i = 1; i < 5; i++) ed.push_back(pk[i]);
      query();
    end
    chk("program count", 8, pa.size());
    foreach (pa[i])
    begin
      chk("program addr", 32'h0000_0100 + i, pa[i]);
      chk("program data", ed[i], pa_d[i]);
    end
    send('{CMD_SEND_DATA, 8'h11}, 8'h00, SBL_ACK);
    st = STAT_INVALID;
    query();
    send('{CMD_RESET}, 8'h00, SBL_ACK);
    n = 0;
    while (srst !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("soft reset", 1, srst);
    reset_sync();
    ra = $random(seed);
    pk = '{CMD_RUN};
    w32(ra);
    send(pk, 8'h00, SBL_ACK);
    n = 0;
    while (run !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("run", 1, run);
    chk("run addr", ra, run_addr);
    // Fresh start on the sync port: first non-zero byte there locks it
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    use_ssi = 1'b1;
    fss_n = 1'b0;
    send('{CMD_PING}, 8'h00, SBL_ACK);
    chk("link ssi", P_SSI, link);
    chk("miso oe", 0, miso_oe_n);
    send('{8'h30}, 8'h00, SBL_ACK);
    st = STAT_UNKNOWN;
    query();
    fss_n = 1'b1;
    stop_test();
  end

  initial
  begin
    repeat (95000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule // serial_boot_loader_protocol_test
